// ### stcb_checker.sv
// assertions on the register port and level outputs of the threshold bank
`timescale 1ns/1ps
`default_nettype none
`include "stcb_defines.vh"
module stcb_checker
(
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [`STCB_ADDR_W-1:0] reg_addr,
  input wire [`STCB_DATA_W-1:0] reg_wr_data,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [`STCB_DATA_W-1:0] reg_rd_data,
  // watched outputs
  input wire [`STCB_LEVEL_W-1:0] detect_level_two,
  input wire [`STCB_LEVEL_W-1:0] detect_level_three,
  input wire [`STCB_LEVEL_W-1:0] detect_level_four,
  input wire [`STCB_SEL_W-1:0] input0_level_select,
  input wire [`STCB_SEL_W-1:0] input7_level_select,
  input wire [`STCB_LEVEL_W-1:0] input7_level
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  rsvd_zero_a: assert property ($past(reg_rd_en) && $past(reg_addr) != 6'h2E |-> reg_rd_data[23:20] == 4'h0)
    else $error("reserved bits read nonzero");
  wr_lower_a: assert property (reg_wr_en && reg_addr == 6'h2B |=> detect_level_four == $past(reg_wr_data[9:0]))
    else $error("level four not taken from bits 9-0");
  wr_upper_a: assert property (reg_wr_en && reg_addr == 6'h2A |=> detect_level_three == $past(reg_wr_data[19:10]))
    else $error("level three not taken from bits 19-10");
  rb_lower_a: assert property (reg_rd_en && reg_addr == 6'h2B |=> reg_rd_data[9:0] == detect_level_four)
    else $error("level four read back wrong");
  sel_high_a: assert property (reg_wr_en && reg_addr == 6'h2E |=> input7_level_select == $past(reg_wr_data[23:21]))
    else $error("input seven selector wrong");
  sel_low_a: assert property (reg_wr_en && reg_addr == 6'h2E |=> input0_level_select == $past(reg_wr_data[2:0]))
    else $error("input zero selector wrong");
  pick_level_a: assert property (input7_level_select == 3'h2 |=> input7_level == $past(detect_level_two))
    else $error("input seven does not follow level two");
  only_own_a: assert property (!(reg_wr_en && reg_addr == 6'h2A) |=> $stable(detect_level_two))
    else $error("level two changed without its write");
  cover property (reg_wr_en && reg_addr == 6'h2E);
  cover property (reg_rd_en ##1 reg_rd_data != 24'h000000);
  cover property (input7_level_select == 3'h7);
endmodule // stcb_checker
`default_nettype wire

// ### stcb_config_bank.v
// register bank of detection thresholds and per-input threshold selectors
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "stcb_defines.vh"

// How it works
// - word 2Ah keeps level two in bits 9-0, level three in 19-10.
// - upper field of every threshold word has LSB at bit 10, MSB at 19.
// - word 2Bh keeps level five in bits 19-10, level four below it.
// - level four sits at bits 9-0 despite the printed 10-1 range.
// - word 2Ch keeps level seven in bits 19-10, level six in 9-0.
// - lower field of every threshold word has LSB at bit 0, MSB at 9.
// - word 2Dh keeps level nine in bits 19-10, level eight in 9-0.
// - all threshold fields reset to zero.
// - word 2Eh resets to zero, holds eight 3-bit selectors, input 7 highest.
// - a selector value n picks threshold n, zero through seven.
module stcb_config_bank
(
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [`STCB_ADDR_W-1:0] reg_addr,
  input wire [`STCB_DATA_W-1:0] reg_wr_data,
  input wire reg_wr_en,
  input wire reg_rd_en,
  output reg [`STCB_DATA_W-1:0] reg_rd_data,
  // levels zero and one live in a word outside this bank
  input wire [`STCB_LEVEL_W-1:0] detect_level_zero,
  input wire [`STCB_LEVEL_W-1:0] detect_level_one,
  // stored detection levels
  output wire [`STCB_LEVEL_W-1:0] detect_level_two,
  output wire [`STCB_LEVEL_W-1:0] detect_level_three,
  output wire [`STCB_LEVEL_W-1:0] detect_level_four,
  output wire [`STCB_LEVEL_W-1:0] detect_level_five,
  output wire [`STCB_LEVEL_W-1:0] detect_level_six,
  output wire [`STCB_LEVEL_W-1:0] detect_level_seven,
  output wire [`STCB_LEVEL_W-1:0] detect_level_eight,
  output wire [`STCB_LEVEL_W-1:0] detect_level_nine,
  // per-input selectors
  output wire [`STCB_SEL_W-1:0] input0_level_select,
  output wire [`STCB_SEL_W-1:0] input1_level_select,
  output wire [`STCB_SEL_W-1:0] input2_level_select,
  output wire [`STCB_SEL_W-1:0] input3_level_select,
  output wire [`STCB_SEL_W-1:0] input4_level_select,
  output wire [`STCB_SEL_W-1:0] input5_level_select,
  output wire [`STCB_SEL_W-1:0] input6_level_select,
  output wire [`STCB_SEL_W-1:0] input7_level_select,
  // threshold applied to each input, one cycle behind its sources
  output wire [`STCB_LEVEL_W-1:0] input0_level,
  output wire [`STCB_LEVEL_W-1:0] input1_level,
  output wire [`STCB_LEVEL_W-1:0] input2_level,
  output wire [`STCB_LEVEL_W-1:0] input3_level,
  output wire [`STCB_LEVEL_W-1:0] input4_level,
  output wire [`STCB_LEVEL_W-1:0] input5_level,
  output wire [`STCB_LEVEL_W-1:0] input6_level,
  output wire [`STCB_LEVEL_W-1:0] input7_level,
  // one-cycle pulse after any accepted write, so consumers can re-evaluate
  output reg config_updated
);

  // address decode
  wire hit_two_three;
  wire hit_four_five;
  wire hit_six_seven;
  wire hit_eight_nine;
  wire hit_selector;
  wire hit_any;
  // per-word write enables, qualified by the write strobe only
  wire wr_two_three;
  wire wr_four_five;
  wire wr_six_seven;
  wire wr_eight_nine;
  wire wr_selector;

  assign hit_two_three = (reg_addr == `STCB_OFF_PAIR_TWO_THREE);
  assign hit_four_five = (reg_addr == `STCB_OFF_PAIR_FOUR_FIVE);
  assign hit_six_seven = (reg_addr == `STCB_OFF_PAIR_SIX_SEVEN);
  assign hit_eight_nine = (reg_addr == `STCB_OFF_PAIR_EIGHT_NINE);
  assign hit_selector = (reg_addr == `STCB_OFF_SELECTOR_LOW);

  // a read strobe never reaches these, so reading cannot disturb a stored field
  assign wr_two_three = reg_wr_en & hit_two_three;
  assign wr_four_five = reg_wr_en & hit_four_five;
  assign wr_six_seven = reg_wr_en & hit_six_seven;
  assign wr_eight_nine = reg_wr_en & hit_eight_nine;
  assign wr_selector = reg_wr_en & hit_selector;
  assign hit_any = hit_two_three | hit_four_five | hit_six_seven | hit_eight_nine | hit_selector;

  // threshold words
  wire [`STCB_DATA_W-1:0] image_two_three;
  wire [`STCB_DATA_W-1:0] image_four_five;
  wire [`STCB_DATA_W-1:0] image_six_seven;
  wire [`STCB_DATA_W-1:0] image_eight_nine;

  stcb_level_pair u_pair_two_three
  (
    .clk(clk),
    .rst(rst),
    .wr_hit(wr_two_three),
    .wr_data(reg_wr_data),
    .lower_level(detect_level_two),
    .upper_level(detect_level_three),
    .word_image(image_two_three)
  );

  // level four takes the same 9..0 field as every other lower level
  stcb_level_pair u_pair_four_five
  (
    .clk(clk),
    .rst(rst),
    .wr_hit(wr_four_five),
    .wr_data(reg_wr_data),
    .lower_level(detect_level_four),
    .upper_level(detect_level_five),
    .word_image(image_four_five)
  );

  stcb_level_pair u_pair_six_seven
  (
    .clk(clk),
    .rst(rst),
    .wr_hit(wr_six_seven),
    .wr_data(reg_wr_data),
    .lower_level(detect_level_six),
    .upper_level(detect_level_seven),
    .word_image(image_six_seven)
  );

  stcb_level_pair u_pair_eight_nine
  (
    .clk(clk),
    .rst(rst),
    .wr_hit(wr_eight_nine),
    .wr_data(reg_wr_data),
    .lower_level(detect_level_eight),
    .upper_level(detect_level_nine),
    .word_image(image_eight_nine)
  );

  // selector word
  reg [`STCB_DATA_W-1:0] input_threshold_selector_low;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      input_threshold_selector_low <= `STCB_SEL_RESET;
    end
    else if (wr_selector)
    begin
      input_threshold_selector_low <= reg_wr_data;
    end
  end

  assign input0_level_select = input_threshold_selector_low[`STCB_SEL_IN0_LSB +: `STCB_SEL_W];
  assign input1_level_select = input_threshold_selector_low[`STCB_SEL_IN1_LSB +: `STCB_SEL_W];
  assign input2_level_select = input_threshold_selector_low[`STCB_SEL_IN2_LSB +: `STCB_SEL_W];
  assign input3_level_select = input_threshold_selector_low[`STCB_SEL_IN3_LSB +: `STCB_SEL_W];
  assign input4_level_select = input_threshold_selector_low[`STCB_SEL_IN4_LSB +: `STCB_SEL_W];
  assign input5_level_select = input_threshold_selector_low[`STCB_SEL_IN5_LSB +: `STCB_SEL_W];
  assign input6_level_select = input_threshold_selector_low[`STCB_SEL_IN6_LSB +: `STCB_SEL_W];
  assign input7_level_select = input_threshold_selector_low[`STCB_SEL_IN7_LSB +: `STCB_SEL_W];

  // threshold table that the selectors index
  wire [`STCB_LEVEL_W-1:0] level_table [0:`STCB_SEL_INPUTS-1];

  assign level_table[0] = detect_level_zero;
  assign level_table[1] = detect_level_one;
  assign level_table[2] = detect_level_two;
  assign level_table[3] = detect_level_three;
  assign level_table[4] = detect_level_four;
  assign level_table[5] = detect_level_five;
  assign level_table[6] = detect_level_six;
  assign level_table[7] = detect_level_seven;

  // registered selection: a glitch-free level for the comparators, at one cycle of latency;
  // each input keeps its own register so no storage has more than one process driving it
  genvar gi;
  generate
    for (gi = 0; gi < `STCB_SEL_INPUTS; gi = gi + 1)
    begin : g_select
      wire [`STCB_SEL_W-1:0] pick;
      reg [`STCB_LEVEL_W-1:0] chosen;
      assign pick = input_threshold_selector_low[gi*`STCB_SEL_W +: `STCB_SEL_W];
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          chosen <= `STCB_LEVEL_RESET;
        end
        else
        begin
          chosen <= level_table[pick];
        end
      end
    end
  endgenerate

  assign input0_level = g_select[0].chosen;
  assign input1_level = g_select[1].chosen;
  assign input2_level = g_select[2].chosen;
  assign input3_level = g_select[3].chosen;
  assign input4_level = g_select[4].chosen;
  assign input5_level = g_select[5].chosen;
  assign input6_level = g_select[6].chosen;
  assign input7_level = g_select[7].chosen;

  // read path
  reg [`STCB_DATA_W-1:0] read_value;

  always @*
  begin
    read_value = `STCB_READ_IDLE;
    if (hit_two_three)
    begin
      read_value = image_two_three;
    end
    else if (hit_four_five)
    begin
      read_value = image_four_five;
    end
    else if (hit_six_seven)
    begin
      read_value = image_six_seven;
    end
    else if (hit_eight_nine)
    begin
      read_value = image_eight_nine;
    end
    else if (hit_selector)
    begin
      read_value = input_threshold_selector_low;
    end
  end

  // read data stand only in the cycle after the strobe; unmapped offsets read zero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rd_data <= `STCB_READ_IDLE;
    end
    else if (reg_rd_en)
    begin
      reg_rd_data <= read_value;
    end
    else
    begin
      reg_rd_data <= `STCB_READ_IDLE;
    end
  end

  // write notification
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      config_updated <= 1'b0;
    end
    else
    begin
      config_updated <= reg_wr_en & hit_any;
    end
  end

endmodule // stcb_config_bank
`default_nettype wire

// ### stcb_defines.vh
// offsets, field positions, widths and reset values of the switch threshold configuration bank
`ifndef STCB_DEFINES_VH
`define STCB_DEFINES_VH

// register bus geometry
`define STCB_ADDR_W 6
`define STCB_DATA_W 24

// register offsets
`define STCB_OFF_PAIR_TWO_THREE 6'h2A
`define STCB_OFF_PAIR_FOUR_FIVE 6'h2B
`define STCB_OFF_PAIR_SIX_SEVEN 6'h2C
`define STCB_OFF_PAIR_EIGHT_NINE 6'h2D
`define STCB_OFF_SELECTOR_LOW 6'h2E

// threshold word layout
`define STCB_LEVEL_W 10
`define STCB_LOWER_LSB 0
`define STCB_LOWER_MSB 9
`define STCB_UPPER_LSB 10
`define STCB_UPPER_MSB 19
`define STCB_RSVD_LSB 20
`define STCB_RSVD_MSB 23

// selector word layout: input n sits at bits 3n+2 .. 3n
`define STCB_SEL_W 3
`define STCB_SEL_IN0_LSB 0
`define STCB_SEL_IN1_LSB 3
`define STCB_SEL_IN2_LSB 6
`define STCB_SEL_IN3_LSB 9
`define STCB_SEL_IN4_LSB 12
`define STCB_SEL_IN5_LSB 15
`define STCB_SEL_IN6_LSB 18
`define STCB_SEL_IN7_LSB 21
`define STCB_SEL_INPUTS 8

// reset values
`define STCB_LEVEL_RESET 10'h000
`define STCB_SEL_RESET 24'h000000
`define STCB_READ_IDLE 24'h000000

`endif

// ### stcb_host.sv
// host model driving the register port of the threshold bank
`timescale 1ns/1ps
`default_nettype none
`include "stcb_defines.vh"
module stcb_host
(
  // clock
  input wire logic clk,
  // register port
  output logic [`STCB_ADDR_W-1:0] addr,
  output logic [`STCB_DATA_W-1:0] wdata,
  output logic wr_en,
  output logic rd_en,
  input wire logic [`STCB_DATA_W-1:0] rdata
);
  initial
  begin
    addr = 6'h00;
    wdata = 24'h000000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // call just after a rising edge; returns one step after the taking edge
  task wr(input logic [`STCB_ADDR_W-1:0] a, input logic [`STCB_DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    // idle lines show the inverse so stale data is never mistaken for fresh
    wdata <= ~d;
    addr <= ~a;
    #1;
  endtask
  task rd(input logic [`STCB_ADDR_W-1:0] a, output logic [`STCB_DATA_W-1:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule // stcb_host
`default_nettype wire

// ### stcb_level_pair.v
// one threshold word holding a lower and an upper 10-bit detection level
`timescale 1ns/1ps
`default_nettype none
`include "stcb_defines.vh"

module stcb_level_pair
(
  // clock and reset
  input wire clk,
  input wire rst,
  // write side
  input wire wr_hit,
  input wire [`STCB_DATA_W-1:0] wr_data,
  // stored levels
  output reg [`STCB_LEVEL_W-1:0] lower_level,
  output reg [`STCB_LEVEL_W-1:0] upper_level,
  // read image with reserved bits at zero
  output wire [`STCB_DATA_W-1:0] word_image
);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lower_level <= `STCB_LEVEL_RESET;
      upper_level <= `STCB_LEVEL_RESET;
    end
    else if (wr_hit)
    begin
      // bits 23..20 are never stored, so writes there cannot disturb the levels
      lower_level <= wr_data[`STCB_LOWER_MSB:`STCB_LOWER_LSB];
      upper_level <= wr_data[`STCB_UPPER_MSB:`STCB_UPPER_LSB];
    end
  end

  assign word_image = {4'h0, upper_level, lower_level};

endmodule // stcb_level_pair
`default_nettype wire

// ### test_stcb_config_bank.sv
// self-checking bench of the threshold configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "stcb_defines.vh"
module test_stcb_config_bank;
  logic clk, rst, cu;
  logic [`STCB_LEVEL_W-1:0] z0, z1, lv[2:9], il[8];
  logic [`STCB_SEL_W-1:0] sl[8];
  wire [`STCB_ADDR_W-1:0] ra;
  wire [`STCB_DATA_W-1:0] rwd, rrd;
  wire rwe, rre;
  int error_cnt, n_checks, m[5], i, k;
  logic [31:0] s;
  logic [`STCB_DATA_W-1:0] d;
  stcb_host host (.clk(clk), .addr(ra), .wdata(rwd), .wr_en(rwe), .rd_en(rre), .rdata(rrd));
  stcb_config_bank DUT (.clk(clk), .rst(rst), .reg_addr(ra), .reg_wr_data(rwd), .reg_wr_en(rwe),
    .reg_rd_en(rre), .reg_rd_data(rrd), .detect_level_zero(z0), .detect_level_one(z1),
    .detect_level_two(lv[2]), .detect_level_three(lv[3]), .detect_level_four(lv[4]), .detect_level_five(lv[5]),
    .detect_level_six(lv[6]), .detect_level_seven(lv[7]), .detect_level_eight(lv[8]), .detect_level_nine(lv[9]),
    .input0_level_select(sl[0]), .input1_level_select(sl[1]), .input2_level_select(sl[2]),
    .input3_level_select(sl[3]), .input4_level_select(sl[4]), .input5_level_select(sl[5]),
    .input6_level_select(sl[6]), .input7_level_select(sl[7]), .input0_level(il[0]), .input1_level(il[1]),
    .input2_level(il[2]), .input3_level(il[3]), .input4_level(il[4]), .input5_level(il[5]),
    .input6_level(il[6]), .input7_level(il[7]), .config_updated(cu));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function logic [31:0] nx(input logic [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // threshold table as the model holds it: zero, one, then the stored pairs
  function logic [9:0] lvl(input int n);
    lvl = n == 0 ? z0 : n == 1 ? z1 : 10'(m[(n - 2) / 2] >> (n % 2 * 10));
  endfunction
  function logic [23:0] rexp(input logic [5:0] ad);
    rexp = (ad >= 6'h2A && ad <= 6'h2E) ? 24'(m[ad - 6'h2A]) : 24'h000000;
  endfunction
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_all;
    for (k = 2; k < 10; k++)
      chk(24'(lv[k]), 24'(lvl(k)));
    @(posedge clk);
    #1;
    chk(24'(cu), 24'h000000);
    for (k = 0; k < 8; k++)
    begin
      chk(24'(sl[k]), 24'(m[4] >> (3 * k) & 7));
      chk(24'(il[k]), 24'(lvl(m[4] >> (3 * k) & 7)));
    end
  endtask
  task put(input logic [5:0] ad, input logic [23:0] dd);
    host.wr(ad, dd);
    chk(24'(cu), 24'(ad >= `STCB_OFF_PAIR_TWO_THREE && ad <= `STCB_OFF_SELECTOR_LOW));
    if (ad == `STCB_OFF_SELECTOR_LOW)
      m[4] = dd;
    else if (ad < `STCB_OFF_SELECTOR_LOW)
      m[ad - 6'h2A] = dd & 24'h0FFFFF;
    chk_all;
  endtask
  task rd_all;
    for (k = 6'h28; k < 6'h30; k++)
    begin
      host.rd(6'(k), d);
      chk(d, rexp(6'(k)));
    end
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    z0 = 10'h000;
    z1 = 10'h000;
    s = 32'h1cee;
    for (i = 0; i < 5; i++)
      m[i] = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    rd_all;
    for (i = 0; i < 40; i++)
    begin
      s = nx(s);
      z0 <= s[9:0];
      z1 <= s[19:10];
      s = nx(s);
      d = s[23:0];
      put(6'h2A + 6'(s[31:24] % 6), d);
      host.rd(6'h2A + 6'(s[31:24] % 6), d);
      chk(d, rexp(6'h2A + 6'(s[31:24] % 6)));
    end
    // every selector code on every input, each input offset from its neighbour
    for (i = 0; i < 8; i++)
    begin
      d = 24'h000000;
      for (k = 0; k < 8; k++)
        d = d | 24'((i + k) % 8) << (3 * k);
      put(`STCB_OFF_SELECTOR_LOW, d);
    end
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    for (i = 0; i < 5; i++)
      m[i] = 0;
    rd_all;
    chk_all;
    results;
  end
  initial
  begin
    #100000;
    error_cnt++;
    results;
  end
endmodule // test_stcb_config_bank
bind stcb_config_bank stcb_checker chk_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .detect_level_two(detect_level_two),
  .detect_level_three(detect_level_three), .detect_level_four(detect_level_four),
  .input0_level_select(input0_level_select), .input7_level_select(input7_level_select), .input7_level(input7_level));
`default_nettype wire
